/* File: src/msgin_seq.sv */
`timescale 1ns/1ps
module msgin_seq
  import msgin_seq_pkg::*;
(
  // clock and master reset line
  input  wire logic                           clk,
  input  wire logic                           resetn,
  // register port
  input  wire logic [msgin_seq_pkg::ADDR_W-1:0] addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic [31:0]                         rdata,
  // scsi bus information phase
  input  wire logic                           scsi_req,
  input  wire logic [2:0]                     scsi_phase,
  input  wire logic [7:0]                     scsi_data,
  input  wire logic                           scsi_parity_err,
  output logic                                scsi_ack,
  // bus events
  input  wire logic                           cdb_done,
  input  wire logic                           sel_timeout,
  input  wire logic                           selected_as_target,
  input  wire logic                           reselect_same,
  input  wire logic                           reselect_other,
  input  wire logic                           target_disconnect,
  input  wire logic                           bus_reset,
  input  wire logic                           control_error,
  // status
  output logic                                busy
);

  typedef struct packed {
    seq_t        seq;
    logic [3:0]  code;
    logic        hd;
    logic        ddir;
    logic [7:0]  lun;
    logic [15:0] tc;
    logic [15:0] backup;
    logic [FI_W-1:0] function_interrupt_status;
    logic [EI_W-1:0] error_interrupt_status;
    logic        saved_pointer_flag;
    logic        ack;
    logic        end_after;
    logic        done_after;
    logic        busy;
    logic [31:0] rdata;
  } state_t;

  state_t           s;
  state_t           next_s;
  logic             rx_push;
  logic             rx_ready;
  logic             rx_valid;
  logic             rx_pop;
  logic [7:0]       rx_data;
  logic [RX_AW:0]   rx_level;
  logic             wr_ctrl;
  logic             chip_reset;
  logic             pause;
  logic             tc_zero;
  logic             is_id;
  logic             lun_match;
  logic [FI_W-1:0]  fi_set;
  logic [EI_W-1:0]  ei_set;

  assign rdata    = s.rdata;
  assign scsi_ack = s.ack;
  assign busy     = s.busy;

  ////////////////////////////////////////////////////////////////////////////
  // receive fifo for status and command-complete bytes
  rx_byte_fifo u_rx (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (chip_reset),
    .in_valid  (rx_push),
    .in_ready  (rx_ready),
    .in_data   (scsi_data),
    .out_valid (rx_valid),
    .out_ready (rx_pop),
    .out_data  (rx_data),
    .level     (rx_level)
  );

  assign wr_ctrl    = wr && (addr == OFF_CTRL);
  assign chip_reset = wr_ctrl && wdata[BIT_CHIPRST];
  assign pause      = wr_ctrl && wdata[BIT_PAUSE];
  assign rx_pop     = rd && (addr == OFF_RXDATA);
  assign tc_zero    = (s.tc == '0);
  assign is_id      = scsi_data[7];
  assign lun_match  = (scsi_data[2:0] == s.lun[2:0]);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and registers
  always_comb begin
    next_s  = s;
    rx_push = 1'b0;
    fi_set  = '0;
    ei_set  = '0;
    next_s.rdata = '0;

    // register writes
    if (wr) begin
      unique case (addr)
        OFF_CTRL: begin
          next_s.hd   = wdata[BIT_HD];
          next_s.ddir = wdata[BIT_DDIR];
        end
        OFF_CODE: begin
          if (s.seq == SEQ_IDLE) begin
            next_s.code = wdata[3:0];
          end
        end
        OFF_LUN: begin
          next_s.lun = wdata[7:0];
        end
        OFF_COUNT: begin
          if (s.seq == SEQ_IDLE) begin
            next_s.tc = wdata[15:0];
          end
        end
        OFF_FUNC: begin
          next_s.function_interrupt_status = s.function_interrupt_status & ~wdata[FI_W-1:0];
        end
        OFF_ERR: begin
          next_s.error_interrupt_status = s.error_interrupt_status & ~wdata[EI_W-1:0];
        end
        OFF_PHASE: begin
          if (wdata[0]) begin
            next_s.saved_pointer_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the next cycle only
    if (rd) begin
      unique case (addr)
        OFF_CTRL:    next_s.rdata = 32'({s.busy, s.ddir, s.hd}) << BIT_HD;
        OFF_CODE:    next_s.rdata = 32'(s.code);
        OFF_LUN:     next_s.rdata = 32'(s.lun);
        OFF_COUNT:   next_s.rdata = 32'(s.tc);
        OFF_BACKUP:  next_s.rdata = 32'(s.backup);
        OFF_FUNC:    next_s.rdata = 32'(s.function_interrupt_status);
        OFF_ERR:     next_s.rdata = 32'(s.error_interrupt_status);
        OFF_PHASE:   next_s.rdata = 32'(s.saved_pointer_flag);
        OFF_RXDATA:  next_s.rdata = rx_valid ? 32'(rx_data) : '0;
        OFF_RXLEVEL: next_s.rdata = 32'(rx_level);
        default:     next_s.rdata = '0;
      endcase
    end

    // command flow
    unique case (s.seq)
      SEQ_IDLE: begin
        if (wr_ctrl && wdata[BIT_START]) begin
          next_s.seq = (s.code == CODE_IDLE) ? SEQ_ARB : SEQ_RUN;
        end
      end
      SEQ_ARB: begin
        if (cdb_done) begin
          next_s.code = CODE_CDB;
          next_s.seq  = SEQ_RUN;
        end else if (sel_timeout) begin
          ei_set[EI_TOUT] = 1'b1;  // RQ17
          next_s.seq      = SEQ_IDLE;
        end else if (selected_as_target) begin
          fi_set[FI_SEL] = 1'b1;  // RQ17
          next_s.seq     = SEQ_IDLE;
        end else if (reselect_same || reselect_other) begin
          fi_set[FI_RSL] = 1'b1;  // RQ18
          next_s.code    = CODE_IDLE;  // RQ18
          next_s.seq     = SEQ_IDLE;
        end else if (pause) begin
          ei_set[EI_HALT] = 1'b1;  // RQ17
          next_s.seq      = SEQ_IDLE;
        end
      end
      SEQ_RUN: begin
        if (target_disconnect) begin
          next_s.code = CODE_DISC;  // RQ20
          if (s.code != CODE_DISMSG) begin
            ei_set[EI_CERR] = 1'b1;
            next_s.seq      = SEQ_IDLE;
          end else if (s.hd) begin
            fi_set[FI_DIS] = 1'b1;
            next_s.seq     = SEQ_IDLE;
          end
        end else if (s.code == CODE_DISC) begin
          if (reselect_same) begin
            next_s.code = CODE_RESEL;
          end else if (reselect_other) begin
            fi_set[FI_RSL] = 1'b1;
            next_s.seq     = SEQ_IDLE;
          end else if (selected_as_target) begin
            fi_set[FI_SEL] = 1'b1;
            next_s.seq     = SEQ_IDLE;
          end else if (pause) begin
            ei_set[EI_HALT] = 1'b1;
            next_s.seq      = SEQ_IDLE;
          end
        end else if (pause) begin
          ei_set[EI_HALT] = 1'b1;
          next_s.seq      = SEQ_IDLE;
        end else if (scsi_req) begin
          next_s.seq = SEQ_DECODE;  // RQ1
        end
      end
      SEQ_DECODE: begin
        // target holds byte and request while this decides
        next_s.seq = SEQ_ACK;  // RQ21
        next_s.ack = 1'b1;
        if ((scsi_phase == PH_MIN || scsi_phase == PH_STAT) && scsi_parity_err) begin
          fi_set[FI_BUS] = 1'b1;  // RQ3 RQ13
          next_s.ack     = 1'b0;
          next_s.seq     = SEQ_IDLE;
        end else if (scsi_phase == PH_STAT) begin
          if (tc_zero && (s.code == CODE_CDB || s.code == CODE_IDOK ||
                          s.code == CODE_DATAOK || s.code == CODE_SDP)) begin  // RQ14
            if (rx_ready) begin
              rx_push     = 1'b1;  // RQ12
              next_s.code = CODE_STAT;  // RQ12
            end else begin
              next_s.ack = 1'b0;
              next_s.seq = SEQ_DECODE;
            end
          end else begin
            fi_set[FI_BUS] = 1'b1;
            next_s.ack     = 1'b0;
            next_s.seq     = SEQ_IDLE;
          end
        end else if (scsi_phase == PH_MIN) begin
          if (scsi_data == MSG_SDP && (s.code == CODE_CDB || s.code == CODE_DATA ||
                                       s.code == CODE_DATAOK)) begin
            next_s.backup             = s.tc;  // RQ4
            next_s.code               = CODE_SDP;  // RQ4
            next_s.saved_pointer_flag = 1'b1;  // RQ4
          end else if (scsi_data == MSG_DISC &&
                       (s.code == CODE_CDB || s.code == CODE_SDP)) begin  // RQ6
            next_s.code = CODE_DISMSG;  // RQ5
          end else if (is_id && s.code == CODE_RESEL) begin
            if (lun_match) begin
              next_s.code = CODE_IDOK;  // RQ7
            end else begin
              next_s.lun       = scsi_data;  // RQ8
              next_s.end_after = 1'b1;  // RQ8
            end
          end else if (scsi_data == MSG_RESTORE && s.code == CODE_IDOK) begin
            next_s.code = CODE_IDOK;  // RQ9
          end else if (s.code == CODE_STAT &&
                       (scsi_data == MSG_CC || scsi_data == MSG_LCC ||
                        scsi_data == MSG_LCCF)) begin
            if (rx_ready) begin
              rx_push = 1'b1;  // RQ10
              if (scsi_data == MSG_CC) begin
                next_s.code = CODE_CC;  // RQ10
              end else begin
                next_s.code       = CODE_LCC;  // RQ11
                next_s.done_after = 1'b1;  // RQ11
              end
            end else begin
              next_s.ack = 1'b0;
              next_s.seq = SEQ_DECODE;
            end
          end else begin
            fi_set[FI_BUS] = 1'b1;  // RQ2
            next_s.ack     = 1'b0;  // RQ2
            next_s.seq     = SEQ_IDLE;
          end
        end else if ((scsi_phase == PH_DIN || scsi_phase == PH_DOUT) && !tc_zero &&
                     scsi_phase[0] == s.ddir &&
                     (s.code == CODE_CDB || s.code == CODE_DATA ||
                      s.code == CODE_SDP || s.code == CODE_IDOK)) begin
          next_s.tc   = s.tc - 16'h0001;
          next_s.code = (s.tc == 16'h0001) ? CODE_DATAOK : CODE_DATA;  // RQ19
        end else begin
          fi_set[FI_BUS] = 1'b1;
          next_s.ack     = 1'b0;
          next_s.seq     = SEQ_IDLE;
        end
      end
      SEQ_ACK: begin
        if (!scsi_req) begin
          next_s.ack        = 1'b0;
          next_s.end_after  = 1'b0;
          next_s.done_after = 1'b0;
          if (s.end_after) begin
            ei_set[EI_NEWLN] = 1'b1;  // RQ8
            next_s.seq       = SEQ_IDLE;
          end else if (s.done_after) begin
            fi_set[FI_DONE] = 1'b1;  // RQ11
            next_s.seq      = SEQ_IDLE;
          end else if (s.code == CODE_CC) begin
            next_s.seq = SEQ_WAITDIS;  // RQ10
          end else begin
            next_s.seq = SEQ_RUN;
          end
        end
      end
      SEQ_WAITDIS: begin
        if (target_disconnect) begin
          fi_set[FI_DONE] = 1'b1;  // RQ10
          next_s.seq      = SEQ_IDLE;
        end
      end
      default: begin
        next_s.seq = SEQ_IDLE;
      end
    endcase

    // bus reset and control error end any phase
    if (bus_reset || control_error) begin
      fi_set[FI_SRST] = bus_reset;  // RQ16
      ei_set[EI_CERR] = control_error;  // RQ16
      next_s.seq        = SEQ_IDLE;
      next_s.ack        = 1'b0;
      next_s.end_after  = 1'b0;
      next_s.done_after = 1'b0;
    end

    // set wins over a clear in the same cycle
    next_s.function_interrupt_status = next_s.function_interrupt_status | fi_set;
    next_s.error_interrupt_status    = next_s.error_interrupt_status | ei_set;
    next_s.busy = (next_s.seq != SEQ_IDLE);

    if (chip_reset) begin
      next_s = '0;  // RQ15
      next_s.lun = LUN_RST;
      next_s.tc  = COUNT_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s     <= '0;  // RQ15
      s.seq <= SEQ_IDLE;
      s.lun <= LUN_RST;
      s.tc  <= COUNT_RST;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* File: src/msgin_seq_pkg.sv */
// How it works
// RQ1: only single-byte messages; each is decoded before acknowledge, only fitting ones acked.
// RQ2: unacceptable message left unacknowledged and raises bus-service.
// RQ3: message with parity error is not taken; no parity interrupt from this sequencer.
// RQ4: save-data-pointer acked, not stored, counter to backup, code 6, saved flag set.
// RQ5: accepted disconnect message acked, not stored, code becomes 7.
// RQ6: disconnect message accepted only directly after command block or save-data-pointer.
// RQ7: reselection identify with matching LUN acked, not stored, code becomes A.
// RQ8: identify with other LUN written to LUN register, acked, code stays 9, new-LUN end.
// RQ9: restore-pointers after identify acked, not stored, no pointer action.
// RQ10: command complete after status stored; 00 gives code D, completion waits for disconnect.
// RQ11: linked command complete gives code E and completion at once.
// RQ12: status byte stored in receive FIFO, code becomes C.
// RQ13: status with parity error not acked, bus-service raised, no parity interrupt.
// RQ14: status accepted only with zero counter after command, identify, data or save pointer.
// RQ15: chip-reset command or master reset ends any command at once.
// RQ16: bus reset and control error end the command in any phase.
// RQ17: at code 0 failed selection sets timeout, selected or halted flag.
// RQ18: reselection during arbitration ends with code 0 and reselected flag.
// RQ19: counter reaching zero in data phase sets code B.
// RQ20: target disconnect while running sets code 8; after command complete the code stays D.
// RQ21: target holds byte with request until acknowledged or interrupt raised.
package msgin_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam int                ADDR_W       = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CODE     = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_LUN      = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_COUNT    = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_BACKUP   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FUNC     = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_ERR      = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_PHASE    = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_RXDATA   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_RXLEVEL  = 4'h9;

  // control bits
  localparam int BIT_START   = 0;
  localparam int BIT_CHIPRST = 1;
  localparam int BIT_PAUSE   = 2;
  localparam int BIT_HD      = 3;
  localparam int BIT_DDIR    = 4;
  localparam int BIT_BUSY    = 5;

  // function_interrupt_status bits
  localparam int FI_DONE  = 0;
  localparam int FI_BUS   = 1;
  localparam int FI_DIS   = 2;
  localparam int FI_SEL   = 3;
  localparam int FI_RSL   = 4;
  localparam int FI_SRST  = 5;
  localparam int FI_W     = 6;

  // error_interrupt_status bits
  localparam int EI_TOUT  = 0;
  localparam int EI_HALT  = 1;
  localparam int EI_NEWLN = 2;
  localparam int EI_CERR  = 3;
  localparam int EI_W     = 4;

  // command state codes
  localparam logic [3:0] CODE_IDLE   = 4'h0;
  localparam logic [3:0] CODE_CDB    = 4'h4;
  localparam logic [3:0] CODE_DATA   = 4'h5;
  localparam logic [3:0] CODE_SDP    = 4'h6;
  localparam logic [3:0] CODE_DISMSG = 4'h7;
  localparam logic [3:0] CODE_DISC   = 4'h8;
  localparam logic [3:0] CODE_RESEL  = 4'h9;
  localparam logic [3:0] CODE_IDOK   = 4'hA;
  localparam logic [3:0] CODE_DATAOK = 4'hB;
  localparam logic [3:0] CODE_STAT   = 4'hC;
  localparam logic [3:0] CODE_CC     = 4'hD;
  localparam logic [3:0] CODE_LCC    = 4'hE;

  // message bytes
  localparam logic [7:0] MSG_CC      = 8'h00;
  localparam logic [7:0] MSG_SDP     = 8'h02;
  localparam logic [7:0] MSG_RESTORE = 8'h03;
  localparam logic [7:0] MSG_DISC    = 8'h04;
  localparam logic [7:0] MSG_LCC     = 8'h0A;
  localparam logic [7:0] MSG_LCCF    = 8'h0B;

  // bus phases, msg/cd/io
  localparam logic [2:0] PH_DOUT = 3'h0;
  localparam logic [2:0] PH_DIN  = 3'h1;
  localparam logic [2:0] PH_STAT = 3'h3;
  localparam logic [2:0] PH_MIN  = 3'h7;

  // reset values and sizes
  localparam logic [7:0]  LUN_RST   = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam int          RX_DEPTH  = 4;
  localparam int          RX_AW     = 2;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_ARB,
    SEQ_RUN,
    SEQ_DECODE,
    SEQ_ACK,
    SEQ_WAITDIS
  } seq_t;

endpackage

/* File: src/rx_byte_fifo.sv */
`timescale 1ns/1ps
module rx_byte_fifo
  import msgin_seq_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [7:0]       in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [7:0]            out_data,
  output logic [RX_AW:0]        level
);

  typedef struct packed {
    logic [RX_AW-1:0] wp;
    logic [RX_AW-1:0] rp;
    logic [RX_AW:0]   cnt;
  } fifo_t;

  fifo_t      s;
  fifo_t      next_s;
  logic [7:0] mem [RX_DEPTH];
  logic       push;
  logic       pop;

  assign in_ready  = (s.cnt != (RX_AW+1)'(RX_DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data  = mem[s.rp];
  assign level     = s.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (RX_AW+1)'(push) - (RX_AW+1)'(pop);
    if (flush) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end

endmodule

/* File: tb/msgin_seq_checker.sv */
`timescale 1ns/1ps
module msgin_seq_checker
  import msgin_seq_pkg::*;
(
  // clock and reset
  input wire logic                              clk,
  input wire logic                              resetn,
  // register port
  input wire logic [msgin_seq_pkg::ADDR_W-1:0]  addr,
  input wire logic [31:0]                       wdata,
  input wire logic                              wr,
  input wire logic [31:0]                       rdata,
  // scsi bus
  input wire logic                              scsi_req,
  input wire logic                              scsi_parity_err,
  input wire logic                              scsi_ack,
  // events and status
  input wire logic                              bus_reset,
  input wire logic                              control_error,
  input wire logic                              busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_after_decode: assert property ($rose(scsi_ack) |->
    $past(scsi_req, 2) && $past(scsi_req))
    else $error("ack before decode");
  a_parity_no_ack: assert property (scsi_req && scsi_parity_err && !scsi_ack |=>
    !scsi_ack)
    else $error("parity byte acked");
  a_refuse_ends: assert property (scsi_req && scsi_parity_err && busy && !scsi_ack |->
    ##[1:3] !busy)
    else $error("refusal kept busy");
  a_idle_no_ack: assert property (!busy && !scsi_ack |=> !scsi_ack)
    else $error("ack while idle");
  a_ack_holds: assert property (scsi_ack && scsi_req && !wr && !bus_reset && !control_error |=>
    scsi_ack)
    else $error("ack dropped early");
  a_ack_release: assert property (scsi_ack && !scsi_req |=> !scsi_ack)
    else $error("ack stuck");
  a_bus_fault_end: assert property (bus_reset || control_error |-> ##[1:3] !busy)
    else $error("bus fault kept busy");
  a_chip_reset_end: assert property (wr && addr == OFF_CTRL && wdata[BIT_CHIPRST] |->
    ##[1:2] (!busy && !scsi_ack))
    else $error("chip reset kept busy");
  a_master_reset: assert property (disable iff (1'b0) !resetn |=>
    !busy && !scsi_ack && rdata == 32'h0)
    else $error("reset left outputs");
  c_ack: cover property ($rose(scsi_ack));
  c_refused: cover property (scsi_req && !scsi_ack && $fell(busy));
  c_done: cover property ($fell(busy) && !scsi_req);
endmodule
bind msgin_seq msgin_seq_checker u_msgin_seq_checker (
  .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rdata(rdata),
  .scsi_req(scsi_req), .scsi_parity_err(scsi_parity_err), .scsi_ack(scsi_ack),
  .bus_reset(bus_reset), .control_error(control_error), .busy(busy)
);

/* File: tb/scsi_target_model.sv */
`timescale 1ns/1ps
module scsi_target_model (
  // clock and reset
  input wire logic         clk,
  input wire logic         resetn,
  // bench control
  input wire logic         send,
  input wire logic [2:0]   t_phase,
  input wire logic [7:0]   t_byte,
  input wire logic         t_perr,
  input wire logic         abort,
  input wire logic         slow,
  output logic             acked,
  // scsi bus
  input wire logic         scsi_ack,
  output logic             scsi_req,
  output logic [2:0]       scsi_phase,
  output logic [7:0]       scsi_data,
  output logic             scsi_parity_err
);
  logic [1:0] hold;
  always @(posedge clk) begin
    acked <= 1'b0;
    if (!resetn) begin
      scsi_req <= 1'b0;
      scsi_parity_err <= 1'b0;
    end else if (send) begin
      scsi_req <= 1'b1;
      scsi_phase <= t_phase;
      scsi_data <= t_byte;
      scsi_parity_err <= t_perr;
      hold <= slow ? 2'h3 : 2'h0;
    end else if (scsi_req && (abort || (scsi_ack && hold == 2'h0))) begin
      scsi_req <= 1'b0;
      scsi_data <= ~scsi_data;
      scsi_parity_err <= ~scsi_parity_err;
      acked <= scsi_ack;
    end else if (scsi_req && scsi_ack) begin
      hold <= hold - 2'h1;
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import msgin_seq_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0]       wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [31:0]       rdata;
  logic [7:0]        ev = 8'h00;
  logic              busy, scsi_req, scsi_perr, scsi_ack, acked;
  logic [2:0]        scsi_phase;
  logic [7:0]        scsi_data;
  logic              t_send = 1'b0, t_perr = 1'b0, t_abort = 1'b0, t_slow = 1'b0;
  logic [2:0]        t_phase = 3'h0;
  logic [7:0]        t_byte = 8'h00;
  int                miscompares = 0;
  int                checks_done = 0;
  msgin_seq u_msgin_seq (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scsi_req(scsi_req), .scsi_phase(scsi_phase),
    .scsi_data(scsi_data), .scsi_parity_err(scsi_perr), .scsi_ack(scsi_ack),
    .cdb_done(ev[0]), .sel_timeout(ev[1]), .selected_as_target(ev[2]),
    .reselect_same(ev[3]), .reselect_other(ev[4]), .target_disconnect(ev[5]),
    .bus_reset(ev[6]), .control_error(ev[7]), .busy(busy));
  scsi_target_model u_scsi_target_model (.clk(clk), .resetn(resetn), .send(t_send),
    .t_phase(t_phase), .t_byte(t_byte), .t_perr(t_perr), .abort(t_abort), .slow(t_slow),
    .acked(acked), .scsi_ack(scsi_ack), .scsi_req(scsi_req), .scsi_phase(scsi_phase),
    .scsi_data(scsi_data), .scsi_parity_err(scsi_perr));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %0d", a), e, rdata);
  endtask
  task automatic chk_busy();
    chk("busy", 32'h0, 32'(busy));
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  task automatic start(input logic [3:0] c, input logic [15:0] n);
    wr_reg(OFF_CODE, {28'h0, c});
    wr_reg(OFF_COUNT, {16'h0, n});
    wr_reg(OFF_FUNC, 32'h3F);
    wr_reg(OFF_ERR, 32'hF);
    wr_reg(OFF_CTRL, 32'h1);
  endtask
  task automatic send_byte(input logic [2:0] ph, input logic [7:0] b, input logic pe,
                           input logic ea);
    logic got = 1'b0;
    @(posedge clk);
    t_send <= 1'b1;
    t_phase <= ph;
    t_byte <= b;
    t_perr <= pe;
    @(posedge clk);
    t_send <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (acked === 1'b1) got = 1'b1;
    end
    @(posedge clk);
    t_abort <= 1'b1;
    @(posedge clk);
    t_abort <= 1'b0;
    chk("ack", 32'(ea), 32'(got));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    chk_reg(OFF_CODE, 32'h0);
    chk_reg(OFF_LUN, 32'h0);
    chk_reg(OFF_COUNT, 32'h0);
  endtask
  task automatic test_flow();
    t_slow <= 1'b1;
    start(CODE_CDB, 16'h2);
    chk_reg(OFF_CTRL, 32'h20);
    send_byte(PH_MIN, MSG_SDP, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_SDP);
    chk_reg(OFF_BACKUP, 32'h2);
    chk_reg(OFF_PHASE, 32'h1);
    send_byte(PH_MIN, MSG_DISC, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_DISMSG);
    chk_reg(OFF_RXLEVEL, 32'h0);
    pulse(5);
    chk_reg(OFF_CODE, CODE_DISC);
    pulse(3);
    send_byte(PH_MIN, 8'h80, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_IDOK);
    send_byte(PH_MIN, MSG_RESTORE, 1'b0, 1'b1);
    chk_reg(OFF_BACKUP, 32'h2);
    chk_reg(OFF_RXLEVEL, 32'h0);
    send_byte(PH_DOUT, 8'h5A, 1'b0, 1'b1);
    send_byte(PH_DOUT, 8'hA5, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_DATAOK);
    send_byte(PH_STAT, 8'h02, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_STAT);
    send_byte(PH_MIN, MSG_CC, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_CC);
    chk_reg(OFF_FUNC, 32'h0);
    pulse(5);
    chk_reg(OFF_FUNC, 32'h1);
    chk_busy();
    chk_reg(OFF_RXDATA, 32'h02);
    chk_reg(OFF_RXDATA, {24'h0, MSG_CC});
    t_slow <= 1'b0;
  endtask
  task automatic test_refuse();
    logic [23:0] tbl [6] = '{24'h407030, 24'h407021, 24'h403001, 24'h413000,
                             24'h517040, 24'h407010};
    foreach (tbl[i]) begin
      start(tbl[i][23:20], {12'h0, tbl[i][19:16]});
      send_byte(tbl[i][14:12], tbl[i][11:4], tbl[i][0], 1'b0);
      chk_reg(OFF_FUNC, 32'h2);
      chk_reg(OFF_ERR, 32'h0);
      chk_reg(OFF_CODE, {28'h0, tbl[i][23:20]});
      chk_busy();
    end
  endtask
  task automatic test_linked();
    start(CODE_CDB, 16'h0);
    send_byte(PH_STAT, 8'h00, 1'b0, 1'b1);
    send_byte(PH_MIN, MSG_LCC, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_LCC);
    chk_reg(OFF_FUNC, 32'h1);
    chk_busy();
    wr_reg(OFF_CTRL, 32'h2);
    chk_reg(OFF_RXLEVEL, 32'h0);
  endtask
  task automatic test_newlun();
    wr_reg(OFF_LUN, 32'h3);
    start(CODE_DISC, 16'h0);
    pulse(3);
    send_byte(PH_MIN, 8'h85, 1'b0, 1'b1);
    chk_reg(OFF_CODE, CODE_RESEL);
    chk_reg(OFF_LUN, 32'h85);
    chk_reg(OFF_ERR, 32'h4);
    chk_busy();
  endtask
  task automatic test_arb();
    int          idx [3] = '{1, 2, 4};
    logic [31:0] val [3] = '{32'h1, 32'h8, 32'h10};
    foreach (idx[i]) begin
      start(CODE_IDLE, 16'h0);
      pulse(idx[i]);
      chk_reg(i == 0 ? OFF_ERR : OFF_FUNC, val[i]);
      chk_reg(OFF_CODE, 32'h0);
      chk_busy();
    end
    start(CODE_IDLE, 16'h0);
    wr_reg(OFF_CTRL, 32'h4);
    chk_reg(OFF_ERR, 32'h2);
  endtask
  task automatic test_abort();
    start(CODE_CDB, 16'h0);
    pulse(6);
    chk_reg(OFF_FUNC, 32'h20);
    chk_busy();
    start(CODE_SDP, 16'h0);
    pulse(7);
    chk_reg(OFF_ERR, 32'h8);
    chk_busy();
    start(CODE_SDP, 16'h0);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk_reg(OFF_CODE, 32'h0);
    chk_busy();
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    test_reset();
    test_flow();
    test_refuse();
    test_linked();
    test_newlun();
    test_arb();
    test_abort();
    complete_run();
  end
endmodule
